// >>> core/wdt_consts.svh
// Purpose: constants of the watchdog interrupt block
// Assumes: 250 MHz clock, byte-addressed wishbone, 32-bit data
// Notes:   offsets are byte addresses of aligned words
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

`define WDT_CLK_MHZ          250
`define WDT_RECOVER_US       250
`define WDT_RECOVER_CYC      (`WDT_RECOVER_US * `WDT_CLK_MHZ)

`define WDT_ADR_W            8
`define WDT_OFS_CTRL         8'h00
`define WDT_OFS_PERIOD       8'h04
`define WDT_OFS_SERVICE      8'h08
`define WDT_OFS_STATUS       8'h0c
`define WDT_OFS_ACK          8'h10
`define WDT_OFS_IRQ_EN       8'h14
`define WDT_OFS_COUNT        8'h18

`define WDT_SERVICE_KEY_A    32'h0000_a5a5
`define WDT_SERVICE_KEY_B    32'h0000_5a5a
`define WDT_PERIOD_RESET     32'h0001_0000

`define WDT_CTRL_EVT_LSB     0
`define WDT_CTRL_SAFE_BIT    2
`define WDT_ST_PEND_BIT      0
`define WDT_ST_OVR_BIT       1
`define WDT_ST_SAFE_BIT      2
`define WDT_ST_KEY_BIT       3
`define WDT_ACK_BIT          0
`define WDT_IRQ_EN_BIT       0

`endif

// >>> core/wdt_pkg.sv
// Purpose: types of the watchdog interrupt block
// Assumes: constants come from wdt_consts.svh
// Notes:   event codes select what an expiry does
package wdt_pkg;
  typedef enum logic [1:0] {
    EVT_OFF     = 2'b00,
    EVT_POLL    = 2'b01,
    EVT_ROUTE   = 2'b10,
    EVT_RSVD    = 2'b11
  } evt_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_COUNT    = 2'b01,
    ST_OVERRUN  = 2'b10
  } wdt_state_t;
endpackage

// >>> core/wdt_bus_if.sv
// Purpose: decoded register access between bus slave and watchdog core
// Assumes: one-cycle strobes
// Notes:   none
`timescale 1ns/100ps
interface wdt_bus_if;
  logic        wr;
  logic        rd;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        hit;

  modport slave (output wr, output rd, output adr, output wdat, input rdat, input hit);
  modport core  (input wr, input rd, input adr, input wdat, output rdat, output hit);
endinterface

// >>> core/wdt_wb_slave.sv
// Purpose: classic wishbone slave, one access per request, ack one cycle later
// Assumes: 32-bit data, word writes only
// Notes:   unmapped address gives err instead of ack
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_wb_slave
  import wdt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  wdt_bus_if.slave         bus
);
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } wb_state_t;

  wb_state_t s_q;
  wb_state_t s_d;
  logic      req;

  assign req      = cyc_i & stb_i & ~s_q.ack & ~s_q.err;
  assign bus.adr  = adr_i;
  assign bus.wdat = dat_i;
  assign bus.wr   = req & we_i & (&sel_i) & bus.hit;
  assign bus.rd   = req & ~we_i & bus.hit;

  always_comb begin
    s_d     = s_q;
    s_d.ack = req & bus.hit;
    s_d.err = req & ~bus.hit;
    if (bus.rd) begin
      s_d.dat = bus.rdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_o = s_q.ack;
  assign err_o = s_q.err;
  assign dat_o = s_q.dat;
endmodule

// >>> core/watchdog_interrupt_control.sv
// Purpose: watchdog period counter with latched expiry interrupt
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   service is two writes of keys, first then second
// Function
// - when enabled, an expiry raises an interrupt request at that moment.
// - the interrupt is readable as status and forwardable to the controller, chosen by configuration.
// - the interrupt stays pending until software writes an explicit acknowledge.
// - the source enable gates only forwarding, never the latch or the timing.
// - the watchdog request is presented above other hardware interrupt sources.
// - the overrun state ends by itself after 250 us.
// - recovery starts a fresh count with the previously selected period.
// - a valid service during overrun ends it early and restarts the count.
// - a full period without a valid service write makes the watchdog expire.
// - once safe mode is entered, period and event configuration are frozen and the mode cannot be left.
// - after reset the watchdog is in flexible mode and disabled.
// - in flexible mode period and event configuration change at runtime, and event off disables the watchdog.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "wdt_consts.svh"
module watchdog_interrupt_control
  import wdt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic        other_irq_i,
  output logic             wdt_irq_o,
  output logic             other_irq_o,
  output logic             expired_o
);
  localparam logic [31:0] RECOVER_CYC = 32'(`WDT_RECOVER_CYC);

  typedef struct packed {
    wdt_state_t  state;
    evt_cfg_t    evt;
    logic        safe;
    logic [31:0] period;
    logic [31:0] count;
    logic        pend;
    logic        irq_en;
    logic        key_armed;
    logic        expired;
  } core_state_t;

  // power-up: flexible mode, supervision off
  localparam core_state_t RESET_STATE = '{
    state:     ST_IDLE,
    evt:       EVT_OFF,
    safe:      1'b0,
    period:    `WDT_PERIOD_RESET,
    count:     32'h0000_0000,
    pend:      1'b0,
    irq_en:    1'b0,
    key_armed: 1'b0,
    expired:   1'b0
  };

  core_state_t s_q;
  core_state_t s_d;
  wdt_bus_if   bus ();

  logic        expire;
  logic        service;
  logic        cfg_open;
  logic        ack_wr;
  logic        wr_ctrl;
  logic        wr_period;
  logic        wr_service;
  logic        wr_ack;
  logic        wr_irq_en;

  wdt_wb_slave u_slave (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .we_i  (we_i),
    .adr_i (adr_i),
    .sel_i (sel_i),
    .dat_i (dat_i),
    .dat_o (dat_o),
    .ack_o (ack_o),
    .err_o (err_o),
    .bus   (bus)
  );

  // one write strobe per writable register
  always_comb begin
    wr_ctrl    = 1'b0;
    wr_period  = 1'b0;
    wr_service = 1'b0;
    wr_ack     = 1'b0;
    wr_irq_en  = 1'b0;
    if (bus.wr) begin
      if (bus.adr == `WDT_OFS_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (bus.adr == `WDT_OFS_PERIOD) begin
        wr_period = 1'b1;
      end else if (bus.adr == `WDT_OFS_SERVICE) begin
        wr_service = 1'b1;
      end else if (bus.adr == `WDT_OFS_ACK) begin
        wr_ack = 1'b1;
      end else if (bus.adr == `WDT_OFS_IRQ_EN) begin
        wr_irq_en = 1'b1;
      end
    end
  end

  always_comb begin
    bus.hit = 1'b0;
    if (bus.adr == `WDT_OFS_CTRL) begin
      bus.hit = 1'b1;
    end else if (bus.adr == `WDT_OFS_PERIOD) begin
      bus.hit = 1'b1;
    end else if (bus.adr == `WDT_OFS_SERVICE) begin
      bus.hit = 1'b1;
    end else if (bus.adr == `WDT_OFS_STATUS) begin
      bus.hit = 1'b1;
    end else if (bus.adr == `WDT_OFS_ACK) begin
      bus.hit = 1'b1;
    end else if (bus.adr == `WDT_OFS_IRQ_EN) begin
      bus.hit = 1'b1;
    end else if (bus.adr == `WDT_OFS_COUNT) begin
      bus.hit = 1'b1;
    end
  end

  always_comb begin
    bus.rdat = '0;
    if (bus.adr == `WDT_OFS_CTRL) begin
      bus.rdat[`WDT_CTRL_EVT_LSB +: 2] = s_q.evt;
      bus.rdat[`WDT_CTRL_SAFE_BIT]     = s_q.safe;
    end else if (bus.adr == `WDT_OFS_PERIOD) begin
      bus.rdat = s_q.period;
    end else if (bus.adr == `WDT_OFS_STATUS) begin
      bus.rdat[`WDT_ST_PEND_BIT] = s_q.pend;
      bus.rdat[`WDT_ST_OVR_BIT]  = (s_q.state == ST_OVERRUN);
      bus.rdat[`WDT_ST_SAFE_BIT] = s_q.safe;
      bus.rdat[`WDT_ST_KEY_BIT]  = s_q.key_armed;
    end else if (bus.adr == `WDT_OFS_IRQ_EN) begin
      bus.rdat[`WDT_IRQ_EN_BIT] = s_q.irq_en;
    end else if (bus.adr == `WDT_OFS_COUNT) begin
      bus.rdat = s_q.count;
    end
  end

  assign cfg_open = ~s_q.safe;
  assign ack_wr   = wr_ack & bus.wdat[`WDT_ACK_BIT];
  // second key after first completes a service
  assign service  = wr_service & s_q.key_armed
                  & (bus.wdat == `WDT_SERVICE_KEY_B);
  assign expire   = (s_q.state == ST_COUNT) & (s_q.count == 32'h0000_0001) & ~service;

  always_comb begin
    s_d         = s_q;
    s_d.expired = 1'b0;
    if (wr_service) begin
      s_d.key_armed = (bus.wdat == `WDT_SERVICE_KEY_A);
    end
    if (wr_ctrl & cfg_open) begin
      s_d.evt  = evt_cfg_t'(bus.wdat[`WDT_CTRL_EVT_LSB +: 2]);
      s_d.safe = bus.wdat[`WDT_CTRL_SAFE_BIT];
    end
    if (wr_period & cfg_open & (bus.wdat != 32'h0)) begin
      s_d.period = bus.wdat;
    end
    if (wr_irq_en) begin
      s_d.irq_en = bus.wdat[`WDT_IRQ_EN_BIT];
    end
    if (ack_wr) begin
      s_d.pend = 1'b0;
    end
    case (s_q.state)
      ST_IDLE: begin
        if (s_q.evt != EVT_OFF) begin
          s_d.state = ST_COUNT;
          s_d.count = s_q.period;
        end
      end
      ST_COUNT: begin
        if (s_q.evt == EVT_OFF) begin
          s_d.state = ST_IDLE;
        end else if (service) begin
          s_d.count = s_q.period;
        end else if (expire) begin
          s_d.state   = ST_OVERRUN;
          s_d.count   = RECOVER_CYC;
          s_d.expired = 1'b1;
          s_d.pend    = 1'b1;
        end else begin
          s_d.count = s_q.count - 32'h0000_0001;
        end
      end
      ST_OVERRUN: begin
        if (service | (s_q.count == 32'h0000_0001)) begin
          s_d.state = ST_COUNT;
          s_d.count = s_q.period;
        end else begin
          s_d.count = s_q.count - 32'h0000_0001;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // forwarding only when routed and enabled; latch untouched
  assign wdt_irq_o   = s_q.pend & s_q.irq_en & (s_q.evt == EVT_ROUTE);
  assign other_irq_o = other_irq_i & ~wdt_irq_o;
  assign expired_o   = s_q.expired;
endmodule

// >>> verification/wdt_chk.sv
// Purpose: port checker for the watchdog interrupt block
// Assumes: bound to watchdog_interrupt_control
// Notes:   one clock domain, reset disables all
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       we_i,
  input wire logic [7:0] adr_i,
  input wire logic       ack_o,
  input wire logic       err_o,
  input wire logic       other_irq_i,
  input wire logic       wdt_irq_o,
  input wire logic       other_irq_o,
  input wire logic       expired_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic req = cyc_i && stb_i && !ack_o && !err_o;
  wire logic wr  = cyc_i && stb_i && we_i;
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  map_ack_a: assert property (req && adr_i <= `WDT_OFS_COUNT && adr_i[1:0] == 2'h0 |=> ack_o && !err_o)
    else $error("mapped access not acked");
  unmap_err_a: assert property (req && adr_i > `WDT_OFS_COUNT |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  prio_mask_a: assert property (wdt_irq_o |-> !other_irq_o)
    else $error("other request not masked");
  other_pass_a: assert property (!wdt_irq_o |-> other_irq_o == other_irq_i)
    else $error("other request not passed");
  exp_pulse_a: assert property (expired_o |=> !expired_o)
    else $error("expiry pulse too long");
  pend_hold_a: assert property (wdt_irq_o && !wr |=> wdt_irq_o)
    else $error("request dropped without write");
  irq_cause_a: assert property ($rose(wdt_irq_o) |-> expired_o || $past(expired_o) || $past(wr))
    else $error("request rose without cause");
endmodule

// >>> verification/wdt_fw_model.sv
// Purpose: firmware side, wishbone master that services and acknowledges
// Assumes: ack or err one cycle after the take edge
// Notes:   released lines show inverted values
`timescale 1ns/100ps
`include "wdt_consts.svh"
module wdt_fw_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  output logic             hung_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, dat_o, hung_o} = '0;
    sel_o = 4'hf;
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && err_i !== 1'b1 && n < 64);
    hung_o <= (ack_i !== 1'b1 && err_i !== 1'b1);
    r = dat_i;
    e = err_i;
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b00, ~w, ~a, ~d};
  endtask
  task automatic service();
    logic [31:0] r;
    logic        e;
    wb(1'b1, `WDT_OFS_SERVICE, `WDT_SERVICE_KEY_A, r, e);
    wb(1'b1, `WDT_OFS_SERVICE, `WDT_SERVICE_KEY_B, r, e);
  endtask
  task automatic ack();
    logic [31:0] r;
    logic        e;
    wb(1'b1, `WDT_OFS_ACK, 32'h1, r, e);
  endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: self-checking bench of the watchdog interrupt block
// Assumes: period shortened by register write
// Notes:   one full overrun recovery is timed
`timescale 1ns/100ps
`include "wdt_consts.svh"
module tb_top;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, other_irq_i = 1'b0;
  logic        cyc, stb, we, ack, err, hung, wdt_irq, other_irq, expired, e;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, r;
  int          failures = 0, checks_done = 0, nexp = 0, n, k;
  row_t        rows [8] = '{'{1'b1, `WDT_OFS_PERIOD, 32'h20, 32'h0, 1'b0}, '{1'b0, `WDT_OFS_COUNT, 32'h0, 32'h0, 1'b0},
    '{1'b0, `WDT_OFS_PERIOD, 32'h0, 32'h20, 1'b0}, '{1'b1, `WDT_OFS_PERIOD, 32'h0, 32'h0, 1'b0},
    '{1'b0, `WDT_OFS_PERIOD, 32'h0, 32'h20, 1'b0}, '{1'b0, 8'h40, 32'h0, 32'h0, 1'b1},
    '{1'b1, `WDT_OFS_IRQ_EN, 32'h1, 32'h0, 1'b0}, '{1'b0, `WDT_OFS_IRQ_EN, 32'h0, 32'h1, 1'b0}};
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (expired === 1'b1) nexp++;
  always @(posedge hung) begin
    $display("[ERR] bus_answer expected 1 seen 0");
    failures++;
    conclude();
  end
  watchdog_interrupt_control u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
    .other_irq_i(other_irq_i), .wdt_irq_o(wdt_irq), .other_irq_o(other_irq), .expired_o(expired));
  wdt_fw_model u_fw (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .err_i(err), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hung_o(hung));
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", s, x, g);
      failures++;
    end
  endtask
  task automatic wexp(input int lim);
    n = 0;
    while (expired !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n == lim) begin
      $display("[ERR] expiry_wait expected 1 seen 0");
      failures++;
      conclude();
    end
    @(posedge clk_i);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      u_fw.wb(rows[i].w, rows[i].a, rows[i].d, r, e);
      chk("err", rows[i].e, e);
      if (!rows[i].w && !rows[i].e) chk("rdat", rows[i].x, r);
    end
    other_irq_i <= 1'b1;
    u_fw.wb(1'b1, `WDT_OFS_CTRL, 32'h2, r, e);
    wexp(200);
    chk("irq", 1, wdt_irq);
    chk("other", 0, other_irq);
    u_fw.wb(1'b0, `WDT_OFS_STATUS, 32'h0, r, e);
    chk("pend_ovr", 3, r[1:0]);
    u_fw.wb(1'b1, `WDT_OFS_IRQ_EN, 32'h0, r, e);
    chk("gated", 0, wdt_irq);
    u_fw.wb(1'b0, `WDT_OFS_STATUS, 32'h0, r, e);
    chk("latched", 1, r[0]);
    u_fw.wb(1'b1, `WDT_OFS_IRQ_EN, 32'h1, r, e);
    u_fw.wb(1'b1, `WDT_OFS_CTRL, 32'h1, r, e);
    chk("poll", 0, wdt_irq);
    u_fw.wb(1'b1, `WDT_OFS_CTRL, 32'h3, r, e);
    chk("rsvd", 0, wdt_irq);
    u_fw.wb(1'b1, `WDT_OFS_CTRL, 32'h2, r, e);
    chk("route", 1, wdt_irq);
    u_fw.ack();
    chk("acked", 0, wdt_irq);
    chk("pass", 1, other_irq);
    u_fw.service();
    u_fw.wb(1'b0, `WDT_OFS_STATUS, 32'h0, r, e);
    chk("early", 0, r[3:0]);
    k = nexp;
    repeat (8) u_fw.service();
    chk("kept", k, nexp);
    wexp(200);
    wexp(70000);
    chk("recover", 1, n >= `WDT_RECOVER_CYC && n < `WDT_RECOVER_CYC + 100);
    u_fw.wb(1'b1, `WDT_OFS_CTRL, 32'h6, r, e);
    u_fw.wb(1'b1, `WDT_OFS_PERIOD, 32'h40, r, e);
    u_fw.wb(1'b1, `WDT_OFS_CTRL, 32'h0, r, e);
    u_fw.wb(1'b0, `WDT_OFS_PERIOD, 32'h0, r, e);
    chk("frozen", 32'h20, r);
    u_fw.wb(1'b0, `WDT_OFS_STATUS, 32'h0, r, e);
    chk("safe", 1, r[2]);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    u_fw.wb(1'b0, `WDT_OFS_STATUS, 32'h0, r, e);
    chk("rst_st", 0, r[3:0]);
    u_fw.wb(1'b0, `WDT_OFS_PERIOD, 32'h0, r, e);
    chk("rst_per", `WDT_PERIOD_RESET, r);
    u_fw.wb(1'b0, `WDT_OFS_CTRL, 32'h0, r, e);
    chk("rst_ctl", 0, r);
    u_fw.wb(1'b1, `WDT_OFS_CTRL, 32'h1, r, e);
    u_fw.wb(1'b1, `WDT_OFS_CTRL, 32'h0, r, e);
    u_fw.wb(1'b0, `WDT_OFS_COUNT, 32'h0, r, e);
    chk("started", 1, r != 32'h0);
    k = int'(r);
    u_fw.wb(1'b0, `WDT_OFS_COUNT, 32'h0, r, e);
    chk("off_hold", k, r);
    conclude();
  end
endmodule
bind watchdog_interrupt_control wdt_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .ack_o(ack_o), .err_o(err_o), .other_irq_i(other_irq_i),
  .wdt_irq_o(wdt_irq_o), .other_irq_o(other_irq_o), .expired_o(expired_o));
